// ==== ice_checker.sv ====
// Multiplexer channel error checker top
// Function
// [R01] Store device and status, then stop
// [R02] Peripheral conditions never stop processor
// [R03] Check parity on device bus numbers
// [R04] Check parity on control data bytes
// [R05] Flag timing fault on stalled sequence
// [R06] Stall timeout is seventy microseconds
// [R07] Memory bytes expect odd parity
// [R08] Timer restarts per step, idle stops
`timescale 1ns/100ps
`include "ice_params.svh"
module ice_checker #(
   parameter int STALL_CYCLES = `ICE_STALL_CYCLES
) (
   // Clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   // Device bus, from pins
   input  wire ice_pkg::ice_byte_s     i_dev,
   input  wire logic                   i_dev_valid,
   // Control data from memory, same clock
   input  wire ice_pkg::ice_byte_s     i_ctl,
   input  wire logic                   i_ctl_valid,
   // Interface sequence, from pins
   input  wire logic                   i_seq_active,
   input  wire logic                   i_seq_step,
   // Peripheral condition, from pins
   input  wire logic                   i_periph_cond,
   // Processor side
   input  wire logic                   i_stop_ack,
   output logic                        o_store,
   output logic [`ICE_DEV_W-1:0]       o_dev_num,
   output logic [7:0]                  o_status,
   output logic                        o_stop_req,
   output logic                        o_periph_flag
);
   ////////////////////////////////////////////////////////////////////////
   // Fault sequencer state
   ice_pkg::ice_state_e state_reg;

   // Device bus synchroniser stages
   ice_pkg::ice_byte_s  dev_s1_reg;
   ice_pkg::ice_byte_s  dev_s2_reg;

   // Pin strobe synchroniser stages: valid, active, step
   logic [2:0]          pin_s1_reg;
   logic [2:0]          pin_s2_reg;

   // Last valid device number, parity unchecked, for faults without one
   logic [7:0]          dev_last_reg;

   // Settled pin strobes, read only from the second stage
   logic                dev_valid_s;
   logic                seq_active_s;
   logic                seq_step_s;

   // Individual fault sources and their union
   logic                par_dev;
   logic                par_ctl;
   logic                t_exp;
   logic                fault_any;

   // Odd parity over data and parity bit
   function automatic logic odd_ok(input ice_pkg::ice_byte_s b);
      odd_ok = ^{b.data, b.par};
   endfunction : odd_ok

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for pin inputs
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         dev_s1_reg <= '0;
         dev_s2_reg <= '0;
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
      end
      else
      begin
         dev_s1_reg <= i_dev;
         dev_s2_reg <= dev_s1_reg;
         pin_s1_reg <= {i_dev_valid, i_seq_active, i_seq_step};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // Named views of the settled strobes
   // Nothing may read the first stage: it can still be metastable
   assign dev_valid_s  = pin_s2_reg[2];
   assign seq_active_s = pin_s2_reg[1];
   assign seq_step_s   = pin_s2_reg[0];

   // Fault detection, pin inputs from second stage only
   // [R03] device number parity
   // [R07] even count of ones is an error
   assign par_dev = dev_valid_s && !odd_ok(dev_s2_reg);
   // [R04] control byte parity
   assign par_ctl = i_ctl_valid && !odd_ok(i_ctl);

   // [R02] only channel faults; peripheral condition kept out
   // A fault seen outside RUN is dropped, not queued, so one stop
   // reports exactly one status byte
   assign fault_any = par_dev || par_ctl || t_exp;

   ////////////////////////////////////////////////////////////////////////
   // [R06] seventy microsecond stall timer
   // [R08] restart per step, off when idle
   ice_stall_timer #(
      .CYCLES   (STALL_CYCLES)
   ) u_timer (
      .i_clk    (i_clk),
      .i_reset_n(i_reset_n),
      .i_active (seq_active_s),
      .i_step   (seq_step_s),
      .o_expired(t_exp)
   );

   // Last device number seen on the bus
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         dev_last_reg <= 8'h00;
      else if (dev_valid_s)
         dev_last_reg <= dev_s2_reg.data;
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault sequencer: store first, stop afterwards
   // [R02] only own parity and timing faults enter
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         state_reg <= ice_pkg::ST_RUN;
      else
      begin
         case (state_reg)
            ice_pkg::ST_RUN:
               // [R05] timing fault starts the stop
               if (fault_any)
                  state_reg <= ice_pkg::ST_STORE;
            // One cycle for the processor to store number and status
            ice_pkg::ST_STORE:
               state_reg <= ice_pkg::ST_STOP;
            ice_pkg::ST_STOP:
               if (i_stop_ack)
                  state_reg <= ice_pkg::ST_RUN;
            default:
               state_reg <= ice_pkg::ST_RUN;
         endcase
      end
   end

   // [R01] capture device number and status
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         o_dev_num <= 8'h00;
         o_status  <= `ICE_STAT_RESET;
      end
      else if (state_reg == ice_pkg::ST_RUN && fault_any)
      begin
         // Faulting number wins over last valid one
         o_dev_num <= dev_valid_s ? dev_s2_reg.data : dev_last_reg;
         o_status  <= `ICE_STAT_RESET;
         o_status[`ICE_STAT_PAR_BIT]  <= par_dev;
         o_status[`ICE_STAT_TIME_BIT] <= t_exp;
         o_status[`ICE_STAT_CTL_BIT]  <= par_ctl;
      end
   end

   // [R01] store strobe one cycle before stop
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         o_store    <= 1'b0;
         o_stop_req <= 1'b0;
      end
      else
      begin
         o_store    <= (state_reg == ice_pkg::ST_RUN) && fault_any;
         // Request stands until the processor acknowledges it
         o_stop_req <= (state_reg == ice_pkg::ST_STORE) ||
                       (state_reg == ice_pkg::ST_STOP && !i_stop_ack);
      end
   end

   // [R02] peripheral condition reported, never stops
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         o_periph_flag <= 1'b0;
      else
         o_periph_flag <= i_periph_cond;
   end
endmodule : ice_checker

// ==== ice_params.svh ====
// Constants for the channel error checker
`ifndef ICE_PARAMS_SVH
`define ICE_PARAMS_SVH
`define ICE_CLK_MHZ        100
`define ICE_STALL_US       70
`define ICE_STALL_CYCLES   (`ICE_STALL_US * `ICE_CLK_MHZ)
`define ICE_DEV_W          8
`define ICE_STAT_PAR_BIT   0
`define ICE_STAT_TIME_BIT  1
`define ICE_STAT_CTL_BIT   2
`define ICE_STAT_RESET     8'h00
`endif

// ==== ice_pkg.sv ====
// Types for the channel error checker
package ice_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_STORE, ST_STOP} ice_state_e;
   typedef struct packed {
      logic [7:0] data;
      logic       par;
   } ice_byte_s;
endpackage : ice_pkg

// ==== ice_stall_timer.sv ====
// Interface sequence stall timer
`timescale 1ns/100ps
`include "ice_params.svh"
module ice_stall_timer #(
   parameter int CYCLES = `ICE_STALL_CYCLES
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // Sequence control
   input  wire logic i_active,
   input  wire logic i_step,
   // Expiry
   output logic      o_expired
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_reg;

   ////////////////////////////////////////////////////////////////////////
   // Counter restarts each step, holds at zero while idle
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n || !i_active || i_step)
         cnt_reg <= '0;
      else if (cnt_reg != W'(CYCLES))
         cnt_reg <= cnt_reg + W'(1);
   end

   // One pulse when a step overruns its interval
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         o_expired <= 1'b0;
      else
         o_expired <= i_active && !i_step && (cnt_reg == W'(CYCLES - 1));
   end
endmodule : ice_stall_timer

// ==== ice_chk_sva.sv ====
// Concurrent checks on the channel error checker ports
`timescale 1ns/100ps
module ice_chk_sva #(parameter int STALL_CYCLES = 20) (
   input wire logic               i_clk,
   input wire logic               i_reset_n,
   input wire ice_pkg::ice_byte_s i_dev,
   input wire logic               i_dev_valid,
   input wire ice_pkg::ice_byte_s i_ctl,
   input wire logic               i_ctl_valid,
   input wire logic               i_periph_cond,
   input wire logic               i_stop_ack,
   input wire logic               o_store,
   input wire logic [7:0]         o_status,
   input wire logic               o_stop_req,
   input wire logic               o_periph_flag
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Store first, stop request next
   sequence store_stop; o_store ##1 o_stop_req; endsequence
   store_stop_a: assert property (o_store |-> store_stop)
      else $error("stop not after store");
   stop_cause_a: assert property ($rose(o_stop_req) |-> $past(o_store))
      else $error("stop without store");
   ctl_par_a: assert property (i_ctl_valid && !(^i_ctl) && !o_store
      && !o_stop_req |=> o_store && o_status[2]) else $error("ctl parity");
   dev_par_a: assert property (i_dev_valid && !(^i_dev) && !o_store
      && !o_stop_req |-> ##[2:4] o_store && o_status[0]) else $error("dev");
   stop_hold_a: assert property (o_stop_req && !i_stop_ack |=> o_stop_req)
      else $error("stop dropped early");
   ack_drop_a: assert property (o_stop_req && i_stop_ack |-> ##[1:2] !o_stop_req)
      else $error("stop held after ack");
   store_pulse_a: assert property (o_store |=> !o_store)
      else $error("store too long");
   periph_flag_a: assert property (i_periph_cond |=> o_periph_flag)
      else $error("periph flag");
   status_held_a: assert property ($changed(o_status) |-> o_store)
      else $error("status moved");
endmodule : ice_chk_sva
bind ice_checker ice_chk_sva #(.STALL_CYCLES(STALL_CYCLES)) chk (.*);

// ==== ice_periph_model.sv ====
// Peripheral unit model on the channel device bus
`timescale 1ns/100ps
module ice_periph_model (
   input  wire logic          i_clk,
   output ice_pkg::ice_byte_s o_dev,
   output logic               o_dev_valid,
   output logic               o_active,
   output logic               o_step
);
   initial {o_dev, o_dev_valid, o_active, o_step} = '0;
   // Released bus shows the inverse, not a stale number
   task send(input logic [7:0] d, input logic bad);
      o_dev = {d, ~^d ^ bad};
      o_dev_valid = 1'b1;
      @(posedge i_clk) #1;
      o_dev_valid = 1'b0;
      o_dev = ~o_dev;
   endtask : send
   task seq(input int gap);
      o_active = 1'b1;
      repeat (3)
      begin
         repeat (gap) @(posedge i_clk);
         #1 o_step = 1'b1;
         @(posedge i_clk) #1;
         o_step = 1'b0;
      end
      o_active = 1'b0;
   endtask : seq
endmodule : ice_periph_model

// ==== tb_top.sv ====
// Testbench for the channel error checker
`timescale 1ns/100ps
module tb_top;
   localparam int S = 20;
   logic i_clk = 0, i_reset_n = 0, i_ctl_valid = 0, i_stop_ack = 0, cond = 0;
   ice_pkg::ice_byte_s i_ctl = '0, i_dev;
   logic i_dev_valid, act, step, o_store, o_stop_req, o_pf;
   logic [7:0] o_dev_num, o_status;
   int err_count = 0, total_checks = 0, cyc = 0, n;
   ice_periph_model pm (.i_clk(i_clk), .o_dev(i_dev),
      .o_dev_valid(i_dev_valid), .o_active(act), .o_step(step));
   ice_checker #(.STALL_CYCLES(S)) dut (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_dev(i_dev), .i_dev_valid(i_dev_valid),
      .i_ctl(i_ctl), .i_ctl_valid(i_ctl_valid), .i_seq_active(act),
      .i_seq_step(step), .i_periph_cond(cond), .i_stop_ack(i_stop_ack),
      .o_store(o_store), .o_dev_num(o_dev_num), .o_status(o_status),
      .o_stop_req(o_stop_req), .o_periph_flag(o_pf));
   initial forever #5 i_clk = ~i_clk;
   // Hang guard
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         summarize();
      end
   end
   task chk(input logic [7:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED %0t value %h want %h", $time, s, e);
      end
   endtask : chk
   task ws;
      n = 0;
      while (o_store !== 1'b1 && n < 100)
      begin
         @(posedge i_clk) #1;
         n++;
      end
   endtask : ws
   // One fault: record, then stop until acknowledged
   task fault(input logic [7:0] st, dn);
      ws();
      chk(o_store, 1);
      chk(o_status, st);
      chk(o_dev_num, dn);
      @(posedge i_clk) #1;
      chk(o_stop_req, 1);
      i_stop_ack = 1;
      repeat (3) @(posedge i_clk) #1;
      i_stop_ack = 0;
      chk(o_stop_req, 0);
   endtask : fault
   task ctl(input ice_pkg::ice_byte_s b);
      i_ctl = b;
      i_ctl_valid = 1;
      @(posedge i_clk) #1;
      i_ctl_valid = 0;
   endtask : ctl
   task t_ctl;
      pm.send(8'h5a, 0);
      ctl({8'h81, 1'b1});
      chk(o_stop_req, 0);
      ctl({8'h81, 1'b0});
      fault(8'h04, 8'h5a);
   endtask : t_ctl
   task t_cond;
      cond = 1;
      repeat (2) @(posedge i_clk) #1;
      chk(o_pf, 1);
      repeat (8) @(posedge i_clk) #1;
      chk(o_stop_req, 0);
      cond = 0;
   endtask : t_cond
   // Stall only counts inside a sequence
   task t_stall;
      pm.send(8'h3c, 0);
      pm.seq(17);
      repeat (100) @(posedge i_clk) #1;
      chk(o_stop_req, 0);
      pm.o_active = 1;
      ws();
      chk(8'(n >= S && n <= S + 6), 1);
      pm.o_active = 0;
      fault(8'h02, 8'h3c);
   endtask : t_stall
   task summarize;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (12) @(posedge i_clk);
      #1 i_reset_n = 1;
      repeat (3) @(posedge i_clk) #1;
      t_ctl();
      pm.send(8'ha5, 1);
      fault(8'h01, 8'ha5);
      t_cond();
      t_stall();
      summarize();
   end
endmodule : tb_top
